// ---- rtl/tecpwm_defs.vh ----
// Constants for the event counter / trigger PWM timer channel.
// Assumes inclusion by its bare name from the design file and the testbench.
`ifndef TECPWM_DEFS_VH
`define TECPWM_DEFS_VH
// Register byte offsets.
`define TECPWM_OFF_RUN 8'h00
`define TECPWM_OFF_MODE 8'h04
`define TECPWM_OFF_OUTC 8'h08
`define TECPWM_OFF_EDGE 8'h0C
`define TECPWM_OFF_CMP0 8'h10
`define TECPWM_OFF_CMP1 8'h14
`define TECPWM_OFF_CMP2 8'h18
`define TECPWM_OFF_CMP3 8'h1C
`define TECPWM_OFF_CNT 8'h20
`define TECPWM_OFF_STAT 8'h24
// Field positions.
`define TECPWM_RUN_BIT 7
`define TECPWM_SWTRIG_BIT 6
`define TECPWM_EXTCLK_BIT 5
`define TECPWM_EV_EDGE_LO 2
`define TECPWM_TR_EDGE_LO 0
// Mode codes.
`define TECPWM_MODE_EVENT 3'h1
`define TECPWM_MODE_TRIG 3'h2
// Reset values.
`define TECPWM_CNT_IDLE 16'hFFFF
`define TECPWM_CNT_ZERO 16'h0000
`define TECPWM_CMP_RST 16'h0000
`define TECPWM_REG8_RST 8'h00
// AXI responses.
`define TECPWM_RESP_OK 2'h0
`define TECPWM_RESP_SLVERR 2'h2
`endif

// ---- rtl/tecpwm_top.v ----
// Timer channel with event count mode and trigger-started PWM mode, AXI4-Lite slave.
// Assumes event and trigger pins are asynchronous and software clears sticky status by W1C.
//
// Behaviour
// [R1] Mode 001 selects event counting, mode 010 selects trigger-started PWM.
// [R2] Run in event mode: counter FFFF to 0000, load period buffer, count edges.
// [R3] Event mode period match clears counter and raises period interrupt.
// [R4] Event mode drives no square-wave output.
// [R5] Event mode loads secondary buffers and raises their match interrupts.
// [R6] Software must not set period value to zero in event mode.
// [R7] Period FFFF wraps to zero with period interrupt, overflow flag untouched.
// [R8] Event mode period writes reach buffer at once; passed counts wrap around.
// [R9] Software stops counting before lowering the period value.
// [R10] Secondary below period interrupts once per period; above never matches.
// [R11] Run in trigger mode waits; trigger clears counter, starts PWM outputs.
// [R12] Trigger while running restarts counter, toggles square wave, sets PWM high.
// [R13] Trigger is selected external edge or software trigger bit write.
// [R14] Software triggered PWM toggles square wave once per PWM period.
// [R15] PWM output active for compare value clocks of period plus one.
// [R16] Trigger mode period interrupt rises on step after match, counter clears.
// [R17] Trigger mode secondary interrupt rises in the cycle of equality.
// [R18] Trigger mode buffers load at run start and then reload only on period clear.
// [R19] Edge register holds event edge and trigger edge two-bit fields.
// [R20] Software uses interval mode for event-driven timer output.
// [R21] Software selects the internal clock for trigger mode.
// [R22] Writing first secondary compare last arms the batch reload.
// [R23] External inputs are synchronised and edge detected before use.
`timescale 1ns/10ps
`include "tecpwm_defs.vh"
module tecpwm_top (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire event_in,
  input wire trigger_in,
  output wire square_wave_output,
  output wire [2:0] secondary_pwm_output,
  output wire period_compare_interrupt,
  output wire [2:0] secondary_compare_interrupt
);

  // Edge select decode: 00 none, 01 rising, 10 falling, 11 both.
  function edge_hit;
    input [1:0] sel;
    input cur;
    input prev;
    begin
      edge_hit = (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
    end
  endfunction

  // ==========================================================================
  // Registers and state.
  // ==========================================================================
  reg [7:0] run_ff, mode_ff, outc_ff, edge_ff;
  reg [15:0] cmp_ff [0:3];
  reg [15:0] buf_ff [0:3];
  reg [15:0] cnt_ff;
  reg [3:0] stat_ff;
  reg batch_armed_ff;
  reg waiting_ff;
  reg run_d_ff;
  reg sw_trig_ff;
  reg [2:0] pwm_ff;
  reg sq_ff;
  reg per_irq_ff;
  reg [2:0] sec_irq_ff;
  reg ev_s1_ff, ev_s2_ff, ev_s3_ff, tr_s1_ff, tr_s2_ff, tr_s3_ff;
  reg sw_used_ff;
  reg awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  reg [1:0] bresp_ff, rresp_ff;
  reg [31:0] rdata_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg aw_have_ff, w_have_ff;

  wire [2:0] mode = mode_ff[2:0];
  wire run = run_ff[`TECPWM_RUN_BIT];
  wire ev_mode = (mode == `TECPWM_MODE_EVENT); // see [R1]
  wire tr_mode = (mode == `TECPWM_MODE_TRIG); // see [R1]

  // ==========================================================================
  // Input synchronisers and edge detection.
  // ==========================================================================
  // Two stages settle metastability; the third holds the prior level for edge detection.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ev_s1_ff <= 1'b0;
      ev_s2_ff <= 1'b0;
      ev_s3_ff <= 1'b0;
      tr_s1_ff <= 1'b0;
      tr_s2_ff <= 1'b0;
      tr_s3_ff <= 1'b0;
    end else begin
      ev_s1_ff <= event_in; // see [R23]
      ev_s2_ff <= ev_s1_ff;
      ev_s3_ff <= ev_s2_ff;
      tr_s1_ff <= trigger_in; // see [R23]
      tr_s2_ff <= tr_s1_ff;
      tr_s3_ff <= tr_s2_ff;
    end
  end

  wire ev_edge = edge_hit(edge_ff[`TECPWM_EV_EDGE_LO+1:`TECPWM_EV_EDGE_LO],
                          ev_s2_ff, ev_s3_ff); // see [R19] see [R23]
  wire tr_edge = edge_hit(edge_ff[`TECPWM_TR_EDGE_LO+1:`TECPWM_TR_EDGE_LO],
                          tr_s2_ff, tr_s3_ff); // see [R19] see [R23]
  wire trig = tr_mode & run & (tr_edge | sw_trig_ff); // see [R13]

  // ==========================================================================
  // AXI4-Lite write channel.
  // ==========================================================================
  wire aw_take = s_axi_awvalid & awready_ff;
  wire w_take = s_axi_wvalid & wready_ff;
  wire do_write = aw_have_ff & w_have_ff & ~bvalid_ff;
  wire [7:0] wa = awaddr_ff;
  wire wr_run = do_write & (wa == `TECPWM_OFF_RUN);
  wire wr_mode = do_write & (wa == `TECPWM_OFF_MODE);
  wire wr_stat = do_write & (wa == `TECPWM_OFF_STAT);
  wire wr_ok = (wa == `TECPWM_OFF_RUN) | (wa == `TECPWM_OFF_MODE) |
               (wa == `TECPWM_OFF_OUTC) | (wa == `TECPWM_OFF_EDGE) |
               (wa == `TECPWM_OFF_CMP0) | (wa == `TECPWM_OFF_CMP1) |
               (wa == `TECPWM_OFF_CMP2) | (wa == `TECPWM_OFF_CMP3) |
               (wa == `TECPWM_OFF_STAT);

  // Address and data are latched independently, so either may arrive first.
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      bvalid_ff <= 1'b0;
      bresp_ff <= `TECPWM_RESP_OK;
    end else begin
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
        aw_have_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        w_have_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? `TECPWM_RESP_OK : `TECPWM_RESP_SLVERR;
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
      end
      if (bvalid_ff & s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Control registers.
  // ==========================================================================
  // Byte lane 0 carries the 8-bit registers; wstrb[0] gates them.
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_ff <= `TECPWM_REG8_RST;
      mode_ff <= `TECPWM_REG8_RST;
      outc_ff <= `TECPWM_REG8_RST;
      edge_ff <= `TECPWM_REG8_RST;
    end else if (do_write & s_axi_wstrb[0]) begin
      if (wa == `TECPWM_OFF_RUN)
        run_ff <= {wdata_ff[7], 7'h00};
      if (wa == `TECPWM_OFF_MODE)
        mode_ff <= {1'b0, 1'b0, wdata_ff[`TECPWM_EXTCLK_BIT], 2'h0, wdata_ff[2:0]};
      if (wa == `TECPWM_OFF_OUTC)
        outc_ff <= wdata_ff[7:0];
      if (wa == `TECPWM_OFF_EDGE)
        edge_ff <= {4'h0, wdata_ff[3:0]}; // see [R19]
    end
  end

  // The software trigger bit is self-clearing and reads back as zero.
  always @(posedge aclk) begin
    if (!aresetn)
      sw_trig_ff <= 1'b0;
    else
      sw_trig_ff <= wr_mode & s_axi_wstrb[0] & wdata_ff[`TECPWM_SWTRIG_BIT]; // see [R13]
  end

  // Compare registers; a write to the first secondary arms the batch reload.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
      always @(posedge aclk) begin
        if (!aresetn)
          cmp_ff[gi] <= `TECPWM_CMP_RST;
        else if (do_write & (wa == (`TECPWM_OFF_CMP0 + 8'h04 * gi)) & (&s_axi_wstrb[1:0]))
          cmp_ff[gi] <= wdata_ff[15:0];
      end
    end
  endgenerate

  wire wr_cmp1 = do_write & (wa == `TECPWM_OFF_CMP1) & (&s_axi_wstrb[1:0]);

  // ==========================================================================
  // Counter, buffers and compare logic.
  // ==========================================================================
  wire start = run & ~run_d_ff;
  wire per_match = (cnt_ff == buf_ff[0]);
  wire ev_step = ev_mode & run & ~start & ev_edge;
  wire tr_step = tr_mode & run & ~waiting_ff & ~trig;
  wire tr_clear = tr_step & per_match;

  always @(posedge aclk) begin
    if (!aresetn) begin
      run_d_ff <= 1'b0;
      cnt_ff <= `TECPWM_CNT_IDLE;
      waiting_ff <= 1'b1;
      batch_armed_ff <= 1'b0;
      sw_used_ff <= 1'b0;
      buf_ff[0] <= `TECPWM_CMP_RST;
      buf_ff[1] <= `TECPWM_CMP_RST;
      buf_ff[2] <= `TECPWM_CMP_RST;
      buf_ff[3] <= `TECPWM_CMP_RST;
      per_irq_ff <= 1'b0;
      sec_irq_ff <= 3'h0;
      pwm_ff <= 3'h0;
      sq_ff <= 1'b0;
    end else begin
      run_d_ff <= run;
      per_irq_ff <= 1'b0;
      sec_irq_ff <= 3'h0;
      if (wr_cmp1)
        batch_armed_ff <= 1'b1; // see [R22]
      if (!run) begin
        cnt_ff <= `TECPWM_CNT_IDLE;
        waiting_ff <= 1'b1;
        pwm_ff <= 3'h0;
        sq_ff <= 1'b0;
        sw_used_ff <= 1'b0;
      end else if (ev_mode) begin
        // Anytime write: buffers follow the registers every cycle.
        buf_ff[0] <= cmp_ff[0]; // see [R8]
        buf_ff[1] <= cmp_ff[1]; // see [R5]
        buf_ff[2] <= cmp_ff[2];
        buf_ff[3] <= cmp_ff[3];
        sq_ff <= 1'b0; // see [R4]
        pwm_ff <= 3'h0;
        if (start) begin
          cnt_ff <= `TECPWM_CNT_ZERO; // see [R2]
        end else if (ev_step) begin
          if (per_match) begin
            cnt_ff <= `TECPWM_CNT_ZERO; // see [R3] see [R7]
            per_irq_ff <= 1'b1; // see [R3]
          end else begin
            cnt_ff <= cnt_ff + 16'h0001; // see [R8]
          end
          // Secondary match interrupts on the step after equality.
          sec_irq_ff <= {cnt_ff == buf_ff[3], cnt_ff == buf_ff[2],
                         cnt_ff == buf_ff[1]}; // see [R5] see [R10]
        end
      end else if (tr_mode) begin
        if (start)
          for_load_all();
        if (trig) begin
          cnt_ff <= `TECPWM_CNT_ZERO; // see [R11] see [R12]
          waiting_ff <= 1'b0;
          pwm_ff <= 3'h7; // see [R12]
          sq_ff <= ~sq_ff; // see [R12]
          if (sw_trig_ff)
            sw_used_ff <= 1'b1;
        end else if (tr_step) begin
          if (per_match) begin
            cnt_ff <= `TECPWM_CNT_ZERO; // see [R16]
            per_irq_ff <= 1'b1; // see [R16]
            pwm_ff <= 3'h7; // see [R15]
            if (sw_used_ff)
              sq_ff <= ~sq_ff; // see [R14]
            if (batch_armed_ff) begin
              for_load_all(); // see [R18]
              batch_armed_ff <= wr_cmp1;
            end
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        if (tr_step) begin
          // Equality drops the PWM bit and interrupts in the same cycle; the registered PWM pin falls one cycle later.
          sec_irq_ff <= {cnt_ff + 16'h0001 == buf_ff[3] & ~per_match,
                         cnt_ff + 16'h0001 == buf_ff[2] & ~per_match,
                         cnt_ff + 16'h0001 == buf_ff[1] & ~per_match}; // see [R17]
          if (!per_match) begin
            if (cnt_ff + 16'h0001 == buf_ff[1]) pwm_ff[0] <= 1'b0; // see [R15]
            if (cnt_ff + 16'h0001 == buf_ff[2]) pwm_ff[1] <= 1'b0;
            if (cnt_ff + 16'h0001 == buf_ff[3]) pwm_ff[2] <= 1'b0;
          end else begin
            if (buf_ff[1] == 16'h0000) pwm_ff[0] <= 1'b0;
            if (buf_ff[2] == 16'h0000) pwm_ff[1] <= 1'b0;
            if (buf_ff[3] == 16'h0000) pwm_ff[2] <= 1'b0;
          end
        end
      end
    end
  end

  // Batch transfer of all four compare values into the buffers.
  task for_load_all;
    begin
      buf_ff[0] <= cmp_ff[0];
      buf_ff[1] <= cmp_ff[1];
      buf_ff[2] <= cmp_ff[2];
      buf_ff[3] <= cmp_ff[3];
    end
  endtask

  // ==========================================================================
  // Sticky status: hardware set wins over a same-cycle software clear.
  // ==========================================================================
  wire [3:0] irq_set = {sec_irq_ff, per_irq_ff};
  always @(posedge aclk) begin
    if (!aresetn)
      stat_ff <= 4'h0;
    else if (wr_stat & s_axi_wstrb[0])
      stat_ff <= (stat_ff & ~wdata_ff[3:0]) | irq_set;
    else
      stat_ff <= stat_ff | irq_set;
  end

  // ==========================================================================
  // AXI4-Lite read channel.
  // ==========================================================================
  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `TECPWM_OFF_RUN: rd_mux = {24'h000000, run_ff};
      `TECPWM_OFF_MODE: rd_mux = {24'h000000, mode_ff};
      `TECPWM_OFF_OUTC: rd_mux = {24'h000000, outc_ff};
      `TECPWM_OFF_EDGE: rd_mux = {24'h000000, edge_ff};
      `TECPWM_OFF_CMP0: rd_mux = {16'h0000, cmp_ff[0]};
      `TECPWM_OFF_CMP1: rd_mux = {16'h0000, cmp_ff[1]};
      `TECPWM_OFF_CMP2: rd_mux = {16'h0000, cmp_ff[2]};
      `TECPWM_OFF_CMP3: rd_mux = {16'h0000, cmp_ff[3]};
      // Stopped counter reads as zero rather than the idle FFFF value.
      `TECPWM_OFF_CNT: rd_mux = {16'h0000, run ? cnt_ff : `TECPWM_CNT_ZERO};
      `TECPWM_OFF_STAT: rd_mux = {27'h0000000, waiting_ff, stat_ff};
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `TECPWM_RESP_OK;
    end else begin
      if (s_axi_arvalid & arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_ok ? `TECPWM_RESP_OK : `TECPWM_RESP_SLVERR;
      end else if (rvalid_ff & s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Outputs; pin enables from the output control register gate the pins.
  // ==========================================================================
  reg sq_out_ff;
  reg [2:0] pwm_out_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sq_out_ff <= 1'b0;
      pwm_out_ff <= 3'h0;
    end else begin
      sq_out_ff <= tr_mode & outc_ff[0] & sq_ff; // see [R4]
      pwm_out_ff <= {outc_ff[6] & pwm_ff[2], outc_ff[4] & pwm_ff[1],
                     outc_ff[2] & pwm_ff[0]};
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign square_wave_output = sq_out_ff;
  assign secondary_pwm_output = pwm_out_ff;
  assign period_compare_interrupt = per_irq_ff;
  assign secondary_compare_interrupt = sec_irq_ff;

endmodule // tecpwm_top

// ---- testbench/tecpwm_asserts.sv ----
// Port-level checker for the event counter and trigger PWM channel.
// Assumes it is bound to tecpwm_top and sees only its ports.
`timescale 1ns/10ps
module tecpwm_asserts (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_awvalid,
  input wire s_axi_wready,
  input wire s_axi_wvalid,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire square_wave_output,
  input wire [2:0] secondary_pwm_output,
  input wire period_compare_interrupt,
  input wire [2:0] secondary_compare_interrupt
);
  // ==========================================
  // Checks
  // One domain, so clock and reset are given once.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_quiet_a: assert property ($rose(aresetn) |-> !square_wave_output && !period_compare_interrupt
    && secondary_pwm_output == 3'h0 && secondary_compare_interrupt == 3'h0)
    else $error("outputs not quiet after reset");
  per_pulse_a: assert property (period_compare_interrupt |=> !period_compare_interrupt)
    else $error("period interrupt longer than one cycle");
  sec_pulse_a: assert property (secondary_compare_interrupt[0] |=> !secondary_compare_interrupt[0])
    else $error("secondary interrupt longer than one cycle");
  pwm_fall_a: assert property ($fell(secondary_pwm_output[0]) |-> secondary_compare_interrupt[0]
    || $past(secondary_compare_interrupt[0])) else $error("PWM fell without a compare match");
  pwm_start_a: assert property (period_compare_interrupt && secondary_pwm_output[2]
    |-> ##[0:1] secondary_pwm_output[0]) else $error("PWM not raised at period start");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted during response");
endmodule // tecpwm_asserts

bind tecpwm_top tecpwm_asserts chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_awvalid(s_axi_awvalid), .s_axi_wready(s_axi_wready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .square_wave_output(square_wave_output),
  .secondary_pwm_output(secondary_pwm_output), .period_compare_interrupt(period_compare_interrupt),
  .secondary_compare_interrupt(secondary_compare_interrupt));

// ---- testbench/tecpwm_src_model.sv ----
// External event and trigger source for the timer channel.
// Assumes one caller at a time and the channel clock on aclk.
`timescale 1ns/10ps
module tecpwm_src_model (
  input wire aclk,
  output logic event_in,
  output logic trigger_in
);
  // ==========================================
  // Pulse tasks
  // Levels are held four clocks so the synchroniser cannot miss one.
  initial begin
    event_in = 1'b0;
    trigger_in = 1'b0;
  end
  task automatic pulse_event(input int n);
    repeat (n) begin
      @(posedge aclk) event_in <= 1'b1;
      repeat (4) @(posedge aclk);
      event_in <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask
  task automatic pulse_trigger;
    @(posedge aclk) trigger_in <= 1'b1;
    repeat (4) @(posedge aclk);
    trigger_in <= 1'b0;
  endtask
endmodule // tecpwm_src_model

// ---- testbench/tecpwm_top_tb.sv ----
// Self-checking bench for the timer channel over AXI4-Lite.
// Assumes the defs header is on the include path.
`timescale 1ns/10ps
`include "tecpwm_defs.vh"
module tecpwm_top_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sq0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [3:0] wstrb;
  logic [1:0] rs;
  wire awready, wready, bvalid, arready, rvalid, sq, per_irq, event_in, trigger_in;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] pwm, sec_irq;
  int error_cnt, num_checks, per_n, i, hi0, hi1, hi2, sq_hi;
  int sec_n[3];
  tecpwm_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .event_in(event_in), .trigger_in(trigger_in),
    .square_wave_output(sq), .secondary_pwm_output(pwm), .period_compare_interrupt(per_irq),
    .secondary_compare_interrupt(sec_irq));
  tecpwm_src_model src_u (.aclk(aclk), .event_in(event_in), .trigger_in(trigger_in));
  // ==========================================
  // Clock, monitors and watchdog
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (per_irq === 1'b1) per_n++;
    for (int k = 0; k < 3; k++) if (sec_irq[k] === 1'b1) sec_n[k]++;
    if (sq === 1'b1) sq_hi++;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    end_sim();
  end
  // ==========================================
  // Bus and check tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    rs = bresp;
    bready <= 1'b0;
  endtask
  // Ready is raised late on purpose so the slave must hold its answer.
  task automatic rdw(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    per_n = 0; sec_n = '{0, 0, 0}; sq_hi = 0;
    aresetn <= 1'b1;
  endtask
  task automatic wait_per;
    do @(posedge aclk); while (per_irq !== 1'b1);
  endtask
  // Counts high cycles over one 20-clock period starting at a period interrupt.
  task automatic duty;
    wait_per();
    hi0 = 0; hi1 = 0; hi2 = 0;
    for (i = 0; i < 20; i++) begin
      hi0 += (pwm[0] === 1'b1); hi1 += (pwm[1] === 1'b1); hi2 += (pwm[2] === 1'b1);
      @(posedge aclk);
    end
    chk(per_irq, 1'b1);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h00000000; wstrb = 4'hF; aresetn = 1'b0;
    do_reset();
    // Registers, an unmapped place and the stopped count.
    wr(`TECPWM_OFF_EDGE, 32'h00000005);
    rdw(`TECPWM_OFF_EDGE); chk(rd, 32'h00000005);
    rdw(8'h30); chk(rs, `TECPWM_RESP_SLVERR);
    wr(8'h34, 32'h00000001); chk(rs, `TECPWM_RESP_SLVERR);
    rdw(`TECPWM_OFF_CNT); chk(rd, 32'h00000000);
    // Event counting: four edges per period, one channel above the period.
    wr(`TECPWM_OFF_MODE, 32'h00000001);
    rdw(`TECPWM_OFF_MODE); chk(rd, 32'h00000001);
    wr(`TECPWM_OFF_OUTC, 32'h00000055);
    wr(`TECPWM_OFF_CMP0, 32'h00000003);
    wr(`TECPWM_OFF_CMP1, 32'h00000001);
    wr(`TECPWM_OFF_CMP2, 32'h00000007);
    wr(`TECPWM_OFF_CMP3, 32'h00000002);
    wr(`TECPWM_OFF_RUN, 32'h00000080);
    src_u.pulse_event(8);
    chk(per_n, 2);
    chk(sec_n[0], 2); chk(sec_n[2], 2); chk(sec_n[1], 0);
    rdw(`TECPWM_OFF_CNT); chk(rd, 32'h00000000);
    src_u.pulse_event(1);
    rdw(`TECPWM_OFF_CNT); chk(rd, 32'h00000001);
    chk(sq_hi, 0);
    // Trigger-started PWM with a 20-clock period.
    do_reset();
    wr(`TECPWM_OFF_EDGE, 32'h00000005);
    wr(`TECPWM_OFF_MODE, 32'h00000002);
    wr(`TECPWM_OFF_OUTC, 32'h00000055);
    wr(`TECPWM_OFF_CMP0, 32'h00000013);
    wr(`TECPWM_OFF_CMP2, 32'h00000005);
    wr(`TECPWM_OFF_CMP3, 32'h00000014);
    wr(`TECPWM_OFF_CMP1, 32'h00000003);
    wr(`TECPWM_OFF_RUN, 32'h00000080);
    repeat (30) @(posedge aclk);
    chk(per_n, 0); chk(pwm, 3'h0);
    src_u.pulse_trigger();
    duty(); chk(hi0, 3); chk(hi1, 5); chk(hi2, 20);
    wr(`TECPWM_OFF_CMP2, 32'h00000002);
    duty(); chk(hi1, 5);
    wr(`TECPWM_OFF_CMP1, 32'h00000006);
    duty(); chk(hi0, 6); chk(hi1, 2);
    // Software trigger in mid-period, after both short outputs fell.
    do @(posedge aclk); while (sec_irq[0] !== 1'b1);
    @(posedge aclk);
    sq0 = sq;
    wr(`TECPWM_OFF_MODE, 32'h00000042);
    for (i = 0; i < 12 && pwm[1:0] !== 2'b11; i++) @(posedge aclk);
    chk(pwm, 3'h7); chk(sq, 1'(~sq0));
    wait_per(); repeat (2) @(posedge aclk); sq0 = sq;
    wait_per(); repeat (2) @(posedge aclk);
    chk(sq, 1'(~sq0));
    end_sim();
  end
endmodule // tecpwm_top_tb
